// *** inc/xcvr_pkg.sv ***
// Constants, operation kinds and register map of the octal add/count/shift transceiver.
// Assumes a single 100 MHz clock domain shared by all users of the package.
package xcvr_pkg;

    // Datapath width
    localparam int DATA_W = 8;
    localparam int COUNT_STEP = 1;

    // Mode select codes, written {mode_select_0, mode_select_1, mode_select_2}
    localparam logic [2:0] MODE_ADD_CARRY = 3'h0;
    localparam logic [2:0] MODE_ADD_PLAIN = 3'h1;
    localparam logic [2:0] MODE_COUNT_EN = 3'h2;
    localparam logic [2:0] MODE_COUNT_FREE = 3'h3;
    localparam logic [2:0] MODE_SHIFT = 3'h4;
    localparam logic [2:0] MODE_LOAD_A = 3'h5;
    localparam logic [2:0] MODE_LOAD_B = 3'h6;
    localparam logic [2:0] MODE_HOLD = 3'h7;

    // Operation classes shared by the datapath and the status logic
    typedef enum logic [2:0] {OP_ADD, OP_COUNT, OP_SHIFT, OP_LOAD, OP_HOLD} op_kind_t;

    // Wishbone register byte addresses
    localparam int WB_ADR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATE = 4'h4;
    localparam logic [3:0] ADDR_OPS = 4'h8;

    // Control register fields
    localparam int CTRL_OVR_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_MODE_MSB = 3;
    localparam int CTRL_CIN_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // State register fields
    localparam int STATE_STATUS_BIT = 8;
    localparam int STATE_MODE_LSB = 9;
    localparam int STATE_MODE_MSB = 11;
    localparam int STATE_OE_A_BIT = 12;
    localparam int STATE_OE_B_BIT = 13;
    localparam int STATE_CLEAR_BIT = 14;

    // Update counter
    localparam int OPS_W = 16;
    localparam logic [15:0] OPS_RESET = 16'h0000;

endpackage : xcvr_pkg

// *** rtl/adder_status.sv ***
// Adder and status generator of the transceiver datapath.
// Assumes all inputs are stable within the clk_i domain; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module adder_status #(
    parameter int WIDTH = xcvr_pkg::DATA_W
) (
    input wire xcvr_pkg::op_kind_t op_kind_i,
    input wire logic use_carry_i,
    input wire logic [WIDTH-1:0] reg_bits_i,
    input wire logic [WIDTH-1:0] a_bus_i,
    input wire logic carry_in_i,
    input wire logic master_clear_n_i,
    output logic [WIDTH-1:0] sum_o,
    output logic status_o
);

    logic [WIDTH:0] full_sum;
    logic carry_result;
    logic terminal_count_flag;
    logic parity_bit;
    logic serial_out;

    // B bus never reaches the adder
    always_comb
    begin
        full_sum = {1'b0, a_bus_i} + {1'b0, reg_bits_i}
                   + {{WIDTH{1'b0}}, (use_carry_i & carry_in_i)};
    end

    assign sum_o = full_sum[WIDTH-1:0];
    assign carry_result = full_sum[WIDTH];
    assign terminal_count_flag = &reg_bits_i;
    assign parity_bit = ^reg_bits_i;
    assign serial_out = reg_bits_i[WIDTH-1];

    // Status follows mode and data with no clock in between
    always_comb
    begin
        status_o = 1'b0;
        if (master_clear_n_i)
        begin
            unique case (op_kind_i)
                xcvr_pkg::OP_ADD:
                begin
                    status_o = carry_result;
                end
                xcvr_pkg::OP_COUNT:
                begin
                    status_o = terminal_count_flag;
                end
                xcvr_pkg::OP_SHIFT:
                begin
                    status_o = serial_out;
                end
                xcvr_pkg::OP_LOAD,
                xcvr_pkg::OP_HOLD:
                begin
                    status_o = parity_bit;
                end
            endcase
        end
    end

endmodule : adder_status

`default_nettype wire

// *** rtl/octal_add_count_shift_transceiver.sv ***
// Octal registered transceiver with add, count, shift, load and hold modes.
// Assumes bus pins and mode pins come from logic clocked by clk_i; Wishbone master on clk_i.
`timescale 1ns/1ps
`default_nettype none

module octal_add_count_shift_transceiver #(
    parameter int WIDTH = xcvr_pkg::DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_clear_n_i,
    input wire logic a_side_drive_en_n_i,
    input wire logic b_side_drive_en_n_i,
    input wire logic mode_select_0_i,
    input wire logic mode_select_1_i,
    input wire logic mode_select_2_i,
    input wire logic carry_serial_enable_in_i,
    input wire logic [WIDTH-1:0] a_side_lines_i,
    output logic [WIDTH-1:0] a_side_lines_o,
    output logic a_side_lines_oe_o,
    input wire logic [WIDTH-1:0] b_side_lines_i,
    output logic [WIDTH-1:0] b_side_lines_o,
    output logic b_side_lines_oe_o,
    output logic status_out_o,
    input wire logic [xcvr_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o
);

    // Internal register and its next value
    logic [WIDTH-1:0] internal_reg_bits_ff;
    logic [WIDTH-1:0] nxt_internal_reg_bits;

    // Software control register
    logic [4:0] ctrl_ff;

    // Update counter
    logic [xcvr_pkg::OPS_W-1:0] ops_ff;

    // Bus slave state
    logic ack_ff;
    logic [31:0] rdat_ff;

    // Effective mode and inputs
    logic [2:0] pin_mode;
    logic [2:0] eff_mode;
    logic eff_carry;
    xcvr_pkg::op_kind_t op_kind;
    logic use_carry;
    logic free_count;
    logic load_from_b;
    logic updating;

    // Bus values seen by the datapath
    logic [WIDTH-1:0] a_bus_eff;
    logic [WIDTH-1:0] b_bus_eff;

    // Adder results
    logic [WIDTH-1:0] sum;
    logic status_comb;

    // Bus access decode
    logic wb_req;
    logic wb_wr;
    logic [31:0] state_word;
    logic [31:0] nxt_rdat;

    // Mode comes from pins unless software has taken over
    assign pin_mode = {mode_select_0_i, mode_select_1_i, mode_select_2_i};

    always_comb
    begin
        if (ctrl_ff[xcvr_pkg::CTRL_OVR_BIT])
        begin
            eff_mode = ctrl_ff[xcvr_pkg::CTRL_MODE_MSB:xcvr_pkg::CTRL_MODE_LSB];
            eff_carry = ctrl_ff[xcvr_pkg::CTRL_CIN_BIT];
        end
        else
        begin
            eff_mode = pin_mode;
            eff_carry = carry_serial_enable_in_i;
        end
    end

    // Mode decode
    always_comb
    begin
        op_kind = xcvr_pkg::OP_HOLD;
        use_carry = 1'b0;
        free_count = 1'b0;
        load_from_b = 1'b0;
        unique case (eff_mode)
            xcvr_pkg::MODE_ADD_CARRY:
            begin
                op_kind = xcvr_pkg::OP_ADD;
                use_carry = 1'b1;
            end
            xcvr_pkg::MODE_ADD_PLAIN:
            begin
                op_kind = xcvr_pkg::OP_ADD;
                use_carry = 1'b0;
            end
            xcvr_pkg::MODE_COUNT_EN:
            begin
                op_kind = xcvr_pkg::OP_COUNT;
                free_count = 1'b0;
            end
            xcvr_pkg::MODE_COUNT_FREE:
            begin
                op_kind = xcvr_pkg::OP_COUNT;
                free_count = 1'b1;
            end
            xcvr_pkg::MODE_SHIFT:
            begin
                op_kind = xcvr_pkg::OP_SHIFT;
            end
            xcvr_pkg::MODE_LOAD_A:
            begin
                op_kind = xcvr_pkg::OP_LOAD;
                load_from_b = 1'b0;
            end
            xcvr_pkg::MODE_LOAD_B:
            begin
                op_kind = xcvr_pkg::OP_LOAD;
                load_from_b = 1'b1;
            end
            xcvr_pkg::MODE_HOLD:
            begin
                op_kind = xcvr_pkg::OP_HOLD;
            end
        endcase
    end

    // A bus that this block drives carries the register itself
    assign a_bus_eff = a_side_drive_en_n_i ? a_side_lines_i : internal_reg_bits_ff;
    assign b_bus_eff = b_side_drive_en_n_i ? b_side_lines_i : internal_reg_bits_ff;

    adder_status #(
        .WIDTH(WIDTH)
    ) u_adder_status (
        .op_kind_i(op_kind),
        .use_carry_i(use_carry),
        .reg_bits_i(internal_reg_bits_ff),
        .a_bus_i(a_bus_eff),
        .carry_in_i(eff_carry),
        .master_clear_n_i(master_clear_n_i),
        .sum_o(sum),
        .status_o(status_comb)
    );

    // Next register value; enables matter only through the bus values used by add and load
    always_comb
    begin
        nxt_internal_reg_bits = internal_reg_bits_ff;
        updating = 1'b0;
        unique case (op_kind)
            xcvr_pkg::OP_ADD:
            begin
                nxt_internal_reg_bits = sum;
                updating = 1'b1;
            end
            xcvr_pkg::OP_COUNT:
            begin
                if (free_count || eff_carry)
                begin
                    nxt_internal_reg_bits = internal_reg_bits_ff
                                            + WIDTH'(xcvr_pkg::COUNT_STEP);
                    updating = 1'b1;
                end
            end
            xcvr_pkg::OP_SHIFT:
            begin
                nxt_internal_reg_bits = {internal_reg_bits_ff[WIDTH-2:0], eff_carry};
                updating = 1'b1;
            end
            xcvr_pkg::OP_LOAD:
            begin
                // Shared input not consulted
                nxt_internal_reg_bits = load_from_b ? b_bus_eff : a_bus_eff;
                updating = 1'b1;
            end
            xcvr_pkg::OP_HOLD:
            begin
                nxt_internal_reg_bits = internal_reg_bits_ff;
            end
        endcase
    end

    // Internal register: asynchronous clear, otherwise rising edge only
    always_ff @(posedge clk_i or negedge master_clear_n_i)
    begin
        if (!master_clear_n_i)
        begin
            internal_reg_bits_ff <= '0;
        end
        else if (rst_i)
        begin
            internal_reg_bits_ff <= '0;
        end
        else
        begin
            internal_reg_bits_ff <= nxt_internal_reg_bits;
        end
    end

    // Bus drivers show the register; enables only switch them
    assign a_side_lines_o = internal_reg_bits_ff;
    assign b_side_lines_o = internal_reg_bits_ff;
    assign a_side_lines_oe_o = ~a_side_drive_en_n_i;
    assign b_side_lines_oe_o = ~b_side_drive_en_n_i;

    // Status straight from the combinational generator
    assign status_out_o = status_comb;

    // Wishbone decode
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

    // Control register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= xcvr_pkg::CTRL_RESET;
        end
        else if (wb_wr && (wb_adr_i == xcvr_pkg::ADDR_CTRL) && wb_sel_i[0])
        begin
            ctrl_ff <= wb_dat_i[xcvr_pkg::CTRL_CIN_BIT:xcvr_pkg::CTRL_OVR_BIT];
        end
    end

    // Update counter, cleared by a write
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !master_clear_n_i)
        begin
            ops_ff <= xcvr_pkg::OPS_RESET;
        end
        else if (wb_wr && (wb_adr_i == xcvr_pkg::ADDR_OPS))
        begin
            ops_ff <= xcvr_pkg::OPS_RESET;
        end
        else if (updating)
        begin
            ops_ff <= ops_ff + xcvr_pkg::OPS_W'(xcvr_pkg::COUNT_STEP);
        end
    end

    // Live state word
    always_comb
    begin
        state_word = '0;
        state_word[WIDTH-1:0] = internal_reg_bits_ff;
        state_word[xcvr_pkg::STATE_STATUS_BIT] = status_comb;
        state_word[xcvr_pkg::STATE_MODE_MSB:xcvr_pkg::STATE_MODE_LSB] = eff_mode;
        state_word[xcvr_pkg::STATE_OE_A_BIT] = ~a_side_drive_en_n_i;
        state_word[xcvr_pkg::STATE_OE_B_BIT] = ~b_side_drive_en_n_i;
        state_word[xcvr_pkg::STATE_CLEAR_BIT] = ~master_clear_n_i;
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb
    begin
        nxt_rdat = '0;
        unique case (wb_adr_i)
            xcvr_pkg::ADDR_CTRL:
            begin
                nxt_rdat[xcvr_pkg::CTRL_CIN_BIT:xcvr_pkg::CTRL_OVR_BIT] = ctrl_ff;
            end
            xcvr_pkg::ADDR_STATE:
            begin
                nxt_rdat = state_word;
            end
            xcvr_pkg::ADDR_OPS:
            begin
                nxt_rdat[xcvr_pkg::OPS_W-1:0] = ops_ff;
            end
            default:
            begin
                nxt_rdat = '0;
            end
        endcase
    end

    // Acknowledge one cycle after the request, then drop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= wb_req;
        end
    end

    // Read data captured with the acknowledge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_ff <= '0;
        end
        else if (wb_req && !wb_we_i)
        begin
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

endmodule : octal_add_count_shift_transceiver

`default_nettype wire

// *** tb/xcvr_asserts.sv ***
// Concurrent checks of the transceiver datapath, status output and bus handshake.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module xcvr_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_clear_n_i,
    input wire logic a_side_drive_en_n_i,
    input wire logic b_side_drive_en_n_i,
    input wire logic mode_select_0_i,
    input wire logic mode_select_1_i,
    input wire logic mode_select_2_i,
    input wire logic carry_serial_enable_in_i,
    input wire logic [7:0] a_side_lines_i,
    input wire logic [7:0] a_side_lines_o,
    input wire logic a_side_lines_oe_o,
    input wire logic [7:0] b_side_lines_i,
    input wire logic [7:0] b_side_lines_o,
    input wire logic b_side_lines_oe_o,
    input wire logic status_out_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    wire logic [2:0] md = {mode_select_0_i, mode_select_1_i, mode_select_2_i};
    wire logic mc = master_clear_n_i;
    wire logic ci = carry_serial_enable_in_i;
    wire logic [7:0] q = a_side_lines_o;
    wire logic [8:0] sum = {1'b0, a_side_lines_i} + {1'b0, q} + {8'h00, ci & (md == 3'h0)};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    clear_zero_a: assert property (!mc |-> q == 8'h00 && !status_out_o)
        else $error("Clear did not zero register and status");
    drive_en_a: assert property (a_side_lines_oe_o == !a_side_drive_en_n_i
        && b_side_lines_oe_o == !b_side_drive_en_n_i)
        else $error("Bus enable does not follow its pin");
    same_value_a: assert property (b_side_lines_o == q)
        else $error("Buses show different register values");
    carry_out_a: assert property (mc && md[2:1] == 2'b00 |-> status_out_o == sum[8])
        else $error("Add status is not the carry out");
    add_store_a: assert property (mc && md[2:1] == 2'b00 ##1 mc |-> q == $past(sum[7:0]))
        else $error("Add stored a wrong sum");
    count_step_a: assert property (mc && md == 3'h2 ##1 mc |-> q == $past(q) + {7'h00, $past(ci)})
        else $error("Enabled count stepped wrongly");
    free_count_a: assert property (mc && md == 3'h3 ##1 mc |-> q == $past(q) + 8'h01)
        else $error("Free count did not step by one");
    term_count_a: assert property (mc && md[2:1] == 2'b01 |-> status_out_o == &q)
        else $error("Terminal count flag wrong");
    shift_up_a: assert property (mc && md == 3'h4 |-> status_out_o == q[7]
        ##1 (!mc || q == {$past(q[6:0]), $past(ci)}))
        else $error("Shift moved bits wrongly");
    parity_a: assert property (mc && md >= 3'h5 |-> status_out_o == ^q)
        else $error("Parity status wrong");
    hold_keep_a: assert property (mc && md == 3'h7 ##1 mc |-> $stable(q))
        else $error("Hold changed the register");
    a_capture_a: assert property (mc && md == 3'h5 ##1 mc
        |-> q == $past(a_side_lines_i))
        else $error("Load A stored a wrong value");
    b_capture_a: assert property (mc && md == 3'h6 ##1 mc
        |-> q == $past(b_side_lines_i))
        else $error("Load B stored a wrong value");
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus acknowledge not a single pulse");

    cover property (mc && md == 3'h3 && status_out_o);
    cover property (!mc);
    cover property (wb_ack_o);
endmodule : xcvr_asserts

bind octal_add_count_shift_transceiver xcvr_asserts chk_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .master_clear_n_i(master_clear_n_i),
    .a_side_drive_en_n_i(a_side_drive_en_n_i),
    .b_side_drive_en_n_i(b_side_drive_en_n_i),
    .mode_select_0_i(mode_select_0_i),
    .mode_select_1_i(mode_select_1_i),
    .mode_select_2_i(mode_select_2_i),
    .carry_serial_enable_in_i(carry_serial_enable_in_i),
    .a_side_lines_i(a_side_lines_i),
    .a_side_lines_o(a_side_lines_o),
    .a_side_lines_oe_o(a_side_lines_oe_o),
    .b_side_lines_i(b_side_lines_i),
    .b_side_lines_o(b_side_lines_o),
    .b_side_lines_oe_o(b_side_lines_oe_o),
    .status_out_o(status_out_o),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o)
);

`default_nettype wire

// *** tb/bus_partner.sv ***
// Far-side bus logic for one transceiver bus; resolves the wire level.
// Assumes the device output and enable come from the transceiver on clk_i.
`timescale 1ns/1ps
`default_nettype none

module bus_partner (
    input wire logic clk_i,
    input wire logic drv_i,
    input wire logic [7:0] val_i,
    input wire logic [7:0] dev_i,
    input wire logic dev_oe_i,
    output logic [7:0] lines_o
);
    logic [7:0] last_ff;

    always_ff @(posedge clk_i)
    begin
        last_ff <= lines_o;
    end

    // Far side lets go while the device drives; a floating bus never repeats
    always_comb
    begin
        if (dev_oe_i)
            lines_o = dev_i;
        else if (drv_i)
            lines_o = val_i;
        else
            lines_o = ~last_ff;
    end
endmodule : bus_partner

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the transceiver with far-side bus models.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mc = 1'b1;
    logic ena_n = 1'b1;
    logic enb_n = 1'b1;
    logic cin = 1'b0;
    logic [2:0] md = 3'h7;
    logic [7:0] a_val = 8'h00;
    logic [7:0] b_val = 8'h00;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] rd;
    wire logic [7:0] a_w, b_w, a_o, b_o;
    wire logic a_oe, b_oe, st, wb_ack;
    wire logic [31:0] wb_q;
    int miscompares = 0;
    int check_count = 0;

    always #5 clk_i = ~clk_i;

    octal_add_count_shift_transceiver dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .master_clear_n_i(mc),
        .a_side_drive_en_n_i(ena_n), .b_side_drive_en_n_i(enb_n),
        .mode_select_0_i(md[2]), .mode_select_1_i(md[1]), .mode_select_2_i(md[0]),
        .carry_serial_enable_in_i(cin),
        .a_side_lines_i(a_w), .a_side_lines_o(a_o), .a_side_lines_oe_o(a_oe),
        .b_side_lines_i(b_w), .b_side_lines_o(b_o), .b_side_lines_oe_o(b_oe),
        .status_out_o(st), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
        .wb_sel_i(4'hf), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_ack_o(wb_ack));
    bus_partner pa_u (.clk_i(clk_i), .drv_i(1'b1), .val_i(a_val), .dev_i(a_o),
        .dev_oe_i(a_oe), .lines_o(a_w));
    bus_partner pb_u (.clk_i(clk_i), .drv_i(1'b1), .val_i(b_val), .dev_i(b_o),
        .dev_oe_i(b_oe), .lines_o(b_w));

    task automatic print_verdict;
        begin
            $display("Checks %0d, mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count++;
            if (got !== exp)
            begin
                miscompares++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask : chk

    // Sets mode, carry input, far-side bus values and enables {A,B} at an edge
    task automatic drv(input logic [2:0] m, input logic c, input logic [7:0] a,
        input logic [7:0] b, input logic [1:0] e);
        begin
            @(posedge clk_i);
            md <= m;
            cin <= c;
            a_val <= a;
            b_val <= b;
            {ena_n, enb_n} <= e;
            #1;
        end
    endtask : drv

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
        output logic [31:0] q);
        int n;
        begin
            n = 0;
            q = 32'h00000000;
            @(posedge clk_i);
            wb_cyc <= 1'b1;
            wb_stb <= 1'b1;
            wb_we <= we;
            wb_adr <= adr;
            wb_dat <= wd;
            do
            begin
                @(posedge clk_i);
                n++;
            end
            while (wb_ack !== 1'b1 && n < 20);
            if (wb_ack !== 1'b1)
            begin
                miscompares++;
                print_verdict();
            end
            else
            begin
                q = wb_q;
                wb_cyc <= 1'b0;
                wb_stb <= 1'b0;
                wb_we <= 1'b0;
            end
        end
    endtask : wb

    task automatic t_load;
        begin
            drv(3'h7, 1'b0, 8'h00, 8'h00, 2'b11);
            chk(a_o, 8'h00);
            drv(3'h5, 1'b1, 8'h5a, 8'h00, 2'b11);
            drv(3'h6, 1'b1, 8'h00, 8'h07, 2'b11);
            chk(b_o, 8'h5a);
            drv(3'h5, 1'b0, 8'hff, 8'h00, 2'b01);
            chk(a_o, 8'h07);
            chk(st, 1'b1);
            drv(3'h7, 1'b1, 8'h00, 8'h00, 2'b11);
            chk(a_o, 8'h07);
            chk(st, 1'b1);
            $display("load test done");
        end
    endtask : t_load

    task automatic t_add;
        begin
            drv(3'h5, 1'b0, 8'hff, 8'h00, 2'b11);
            drv(3'h0, 1'b0, 8'h01, 8'h55, 2'b11);
            chk(st, 1'b1);
            drv(3'h1, 1'b1, 8'h03, 8'h55, 2'b11);
            chk(a_o, 8'h00);
            chk(st, 1'b0);
            drv(3'h0, 1'b1, 8'hfe, 8'h00, 2'b11);
            chk(a_o, 8'h03);
            chk(st, 1'b1);
            drv(3'h7, 1'b0, 8'h00, 8'h00, 2'b11);
            chk(a_o, 8'h02);
            $display("add test done");
        end
    endtask : t_add

    task automatic t_count;
        begin
            drv(3'h5, 1'b0, 8'hfe, 8'h00, 2'b11);
            drv(3'h2, 1'b0, 8'h00, 8'h00, 2'b00);
            chk(a_oe & b_oe, 1'b1);
            drv(3'h2, 1'b1, 8'h00, 8'h00, 2'b00);
            chk(a_o, 8'hfe);
            drv(3'h3, 1'b0, 8'h00, 8'h00, 2'b00);
            chk(a_o, 8'hff);
            chk(st, 1'b1);
            drv(3'h7, 1'b0, 8'h00, 8'h00, 2'b11);
            chk(a_o, 8'h00);
            chk(a_oe | b_oe, 1'b0);
            $display("count test done");
        end
    endtask : t_count

    task automatic t_shift;
        begin
            drv(3'h5, 1'b0, 8'h81, 8'h00, 2'b11);
            drv(3'h4, 1'b1, 8'h00, 8'h00, 2'b11);
            chk(st, 1'b1);
            drv(3'h0, 1'b1, 8'hff, 8'h00, 2'b11);
            chk(a_o, 8'h03);
            @(posedge clk_i);
            mc <= 1'b0;
            #1;
            chk(a_o, 8'h00);
            chk(st, 1'b0);
            @(posedge clk_i);
            mc <= 1'b1;
            $display("shift and clear test done");
        end
    endtask : t_shift

    task automatic t_wb;
        begin
            drv(3'h5, 1'b0, 8'h96, 8'h00, 2'b11);
            drv(3'h7, 1'b0, 8'h00, 8'h00, 2'b10);
            wb(1'b0, 4'h4, 32'h00000000, rd);
            chk(rd, 32'h00002e96);
            wb(1'b1, 4'h0, 32'h0000001f, rd);
            wb(1'b0, 4'h0, 32'h00000000, rd);
            chk(rd, 32'h0000001f);
            wb(1'b1, 4'h0, 32'h00000000, rd);
            wb(1'b1, 4'h8, 32'h00000000, rd);
            wb(1'b0, 4'h8, 32'h00000000, rd);
            chk(rd, 32'h00000000);
            wb(1'b0, 4'hc, 32'h00000000, rd);
            chk(rd, 32'h00000000);
            $display("register test done");
        end
    endtask : t_wb

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_load();
        t_add();
        t_count();
        t_shift();
        t_wb();
        print_verdict();
    end
endmodule : tb

`default_nettype wire
